// *** design/tccs_top.sv ***
// Purpose: Transmit framing, data coding, rate timing and signal monitor pin selection
// Assumes: Host writes a byte with TX_LOAD; monitor inputs come from other clock domains
// Notes:   Each bit is cut into four slots; coders place pulses in those slots
//
// Operation
// - Signal-monitor bit 7 puts the I/O pads in fast switching mode.
// - Monitor select 0h or 1h leaves the monitor pin in high impedance.
// - Monitor select 2h drives pin low; 3h drives it high.
// - Monitor select 4h shows the transmit envelope on the pin.
// - Monitor select 5h shows transmitter-active while a transmission runs.
// - Monitor select 6h shows the secure-module serial signal.
// - Monitor select 7h shows receive envelope, valid only for Type A 106 kBd.
// - Monitor select 8h shows the receiver-active indication.
// - Monitor select 9h shows the recovered receive bit signal.
// - Bit-format bit 7 sends bytes high bit first, else low bit first, except under position codes 8h to Bh.
// - Bit-format bit 5 picks odd parity when set, even when clear.
// - Bit-format bit 3 gives the stop bit level.
// - Bit-format bit 1 gives the start bit level.
// - Bit-format bit 0 inserts a start bit before the data, except under position codes 8h to Bh.
// - Coding type in bits 7 to 4; 0h sends data uncoded.
// - Coding type 1h handles a collided stream during anticollision.
// - Types 4h to 6h are return-to-zero, pulse at position one to three; 7h as 6h.
// - Coding type 8h sends 1-out-of-4 pulse position code.
// - Types 9h to Bh send 1-of-256; Ah zero unmodulated, Bh zero in last slot.
// - Coding type Ch sends pulse-interval encoding.
// - Bit 3 set gates non-position-code envelopes with the 848 kHz subcarrier; when clear, no subcarrier is applied.
// - Bit-rate field 2h..7h selects 26 to 848 kHz; 0h and 1h reserved.
module tccs_top
   import tccs_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire tccs_pkg::tccs_bus_req_t BUS_REQ,
   output logic       [7:0]           RD_DATA,
   input  wire logic                  TX_LOAD,
   input  wire logic  [7:0]           TX_BYTE,
   input  wire logic                  TX_PARITY_EN,
   input  wire logic                  TX_COLLIDE_IN,
   input  wire tccs_pkg::tccs_mon_in_t MON_IN,
   output logic                       TX_READY,
   output logic                       TX_ENV_OUT,
   output logic                       TX_ACTIVE_OUT,
   output logic                       FAST_PAD_SWITCHING,
   output logic                       SIG_MON_OUT,
   output logic                       SIG_MON_OE
);
   import tccs_pkg::*;

   typedef struct packed {
      logic [7:0]        sig_mon;
      logic [7:0]        bit_fmt;
      logic [7:0]        data_code;
      logic [7:0]        rdata;
      tccs_state_t       state;
      logic [7:0]        shreg;
      logic [3:0]        bit_cnt;
      logic              parity;
      logic              cur_bit;
      logic [1:0]        slot;
      logic [CNT_W-1:0]  slot_tmr;
      logic [7:0]        sym_cnt;
      logic [7:0]        sym_val;
      logic [CNT_W-1:0]  subc_tmr;
      logic              subc;
      logic              env;
      logic              tx_active;
      logic [5:0]        mon_s1;
      logic [5:0]        mon_s2;
      logic              mon_out;
      logic              mon_oe;
   } tccs_regs_t;

   tccs_regs_t r_ff;
   tccs_regs_t nxt_r;

   // Slot length for a rate code; reserved codes fall back to the slowest rate
   function automatic logic [CNT_W-1:0] slot_len(input logic [2:0] code);
      unique case (code)
         3'h7:    slot_len = SLOT_848;
         3'h6:    slot_len = SLOT_424;
         3'h5:    slot_len = SLOT_212;
         3'h4:    slot_len = SLOT_106;
         3'h3:    slot_len = SLOT_53;
         default: slot_len = SLOT_26;
      endcase
   endfunction : slot_len

   // Bit value that is about to go out, honouring bit order
   function automatic logic next_data_bit(input logic [7:0] sh, input logic msb_first);
      next_data_bit = msb_first ? sh[7] : sh[0];
   endfunction : next_data_bit

   // Pulse level for a slot of the current bit under the selected code
   function automatic logic code_level(input logic [3:0] ct, input logic b, input logic [1:0] sl,
                                       input logic col, input logic sc, input logic subc_en);
      logic lvl;
      lvl = b;
      unique case (ct)
         CODE_COLLIDE: lvl = b ^ col;
         CODE_RZ1:     lvl = b & (sl == 2'd0);
         CODE_RZ2:     lvl = b & (sl == 2'd1);
         CODE_RZ3,
         CODE_RZ3B:    lvl = b & (sl == 2'd2);
         CODE_PIE:     lvl = ~(b ? (sl == 2'd3) : (sl == 2'd1));
         default:      lvl = b;
      endcase
      code_level = subc_en ? (lvl & sc) : lvl;
   endfunction : code_level

   logic [3:0] coding;
   logic       msb_first;
   logic       slot_end;
   logic       bit_end;
   logic       pos_code;
   logic [7:0] sym_slots;

   always_comb begin
      coding    = r_ff.data_code[7:4];
      msb_first = r_ff.bit_fmt[7];
      pos_code  = (coding == CODE_1OF4) || (coding == CODE_1OF256) ||
                  (coding == CODE_1OF256_Z) || (coding == CODE_1OF256_L);
      sym_slots = (coding == CODE_1OF4) ? 8'h03 : 8'hFF;
      slot_end  = (r_ff.slot_tmr == '0);
      bit_end   = slot_end && (r_ff.slot == 2'd3);
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.rdata = 8'h00;

      // Register port, one cycle read latency
      if (BUS_REQ.wr) begin
         unique case (BUS_REQ.addr)
            OFS_SIG_MON:      nxt_r.sig_mon   = BUS_REQ.wdata & SIG_MON_MASK;
            OFS_TX_BIT_FMT:   nxt_r.bit_fmt   = BUS_REQ.wdata & BIT_FMT_MASK;
            OFS_TX_DATA_CODE: nxt_r.data_code = BUS_REQ.wdata;
            default: ;
         endcase
      end
      if (BUS_REQ.rd) begin
         unique case (BUS_REQ.addr)
            OFS_SIG_MON:      nxt_r.rdata = r_ff.sig_mon;
            OFS_TX_BIT_FMT:   nxt_r.rdata = r_ff.bit_fmt;
            OFS_TX_DATA_CODE: nxt_r.rdata = r_ff.data_code;
            OFS_TX_STATUS:    nxt_r.rdata = {6'h00, r_ff.tx_active, r_ff.state == ST_IDLE};
            default:          nxt_r.rdata = 8'h00;
         endcase
      end

      // Subcarrier generator
      if (r_ff.subc_tmr == '0) begin
         nxt_r.subc_tmr = r_ff.data_code[3] ? SUBC_HALF_848 : SUBC_HALF_424;
         nxt_r.subc     = ~r_ff.subc;
      end else begin
         nxt_r.subc_tmr = r_ff.subc_tmr - 1'b1;
      end

      // Slot timer runs only while sending
      if (r_ff.state != ST_IDLE) begin
         if (slot_end) begin
            nxt_r.slot_tmr = slot_len(r_ff.data_code[2:0]) - 1'b1;
            nxt_r.slot     = r_ff.slot + 2'd1;
         end else begin
            nxt_r.slot_tmr = r_ff.slot_tmr - 1'b1;
         end
      end

      unique case (r_ff.state)
         ST_IDLE: begin
            nxt_r.tx_active = 1'b0;
            if (TX_LOAD) begin
               nxt_r.shreg     = TX_BYTE;
               nxt_r.sym_val   = TX_BYTE;
               nxt_r.parity    = 1'b0;
               nxt_r.slot      = 2'd0;
               nxt_r.sym_cnt   = 8'h00;
               nxt_r.slot_tmr  = slot_len(r_ff.data_code[2:0]) - 1'b1;
               nxt_r.tx_active = 1'b1;
               nxt_r.bit_cnt   = 4'd0;
               if (pos_code) begin
                  nxt_r.state = ST_DATA;
               end else if (r_ff.bit_fmt[0]) begin
                  nxt_r.state   = ST_START;
                  nxt_r.cur_bit = r_ff.bit_fmt[1];
               end else begin
                  nxt_r.state   = ST_DATA;
                  nxt_r.cur_bit = next_data_bit(TX_BYTE, r_ff.bit_fmt[7]);
               end
            end
         end
         ST_START: begin
            if (bit_end) begin
               nxt_r.state   = ST_DATA;
               nxt_r.cur_bit = next_data_bit(r_ff.shreg, msb_first);
            end
         end
         ST_DATA: begin
            if (pos_code) begin
               // Position codes: one pulse slot per symbol
               if (slot_end) begin
                  nxt_r.sym_cnt = r_ff.sym_cnt + 8'h01;
                  if (r_ff.sym_cnt == sym_slots) begin
                     if ((coding == CODE_1OF4) && (r_ff.bit_cnt != 4'd3)) begin
                        nxt_r.bit_cnt = r_ff.bit_cnt + 4'd1;
                        nxt_r.sym_val = r_ff.sym_val >> 2;
                        nxt_r.sym_cnt = 8'h00;
                     end else begin
                        nxt_r.state = ST_STOP;
                        nxt_r.cur_bit = r_ff.bit_fmt[3];
                     end
                  end
               end
            end else if (bit_end) begin
               nxt_r.parity  = r_ff.parity ^ r_ff.cur_bit;
               nxt_r.shreg   = msb_first ? {r_ff.shreg[6:0], 1'b0} : {1'b0, r_ff.shreg[7:1]};
               nxt_r.bit_cnt = r_ff.bit_cnt + 4'd1;
               if (r_ff.bit_cnt == 4'd7) begin
                  if (TX_PARITY_EN) begin
                     nxt_r.state   = ST_PAR;
                     nxt_r.cur_bit = r_ff.parity ^ r_ff.cur_bit ^ r_ff.bit_fmt[5];
                  end else begin
                     nxt_r.state   = ST_STOP;
                     nxt_r.cur_bit = r_ff.bit_fmt[3];
                  end
               end else begin
                  nxt_r.cur_bit = msb_first ? r_ff.shreg[6] : r_ff.shreg[1];
               end
            end
         end
         ST_PAR: begin
            if (bit_end) begin
               nxt_r.state   = ST_STOP;
               nxt_r.cur_bit = r_ff.bit_fmt[3];
            end
         end
         ST_STOP: begin
            if (bit_end) begin
               nxt_r.state     = ST_IDLE;
               nxt_r.tx_active = 1'b0;
            end
         end
         default: nxt_r.state = ST_IDLE;
      endcase

      // Envelope; position codes only pulse in their chosen slot
      if (r_ff.state == ST_IDLE) begin
         nxt_r.env = 1'b0;
      end else if (pos_code && (r_ff.state == ST_DATA)) begin
         if (coding == CODE_1OF4) begin
            nxt_r.env = (r_ff.sym_cnt[1:0] == r_ff.sym_val[1:0]);
         end else if ((coding == CODE_1OF256_Z) && (r_ff.sym_val == 8'h00)) begin
            nxt_r.env = 1'b0;
         end else if ((coding == CODE_1OF256_L) && (r_ff.sym_val == 8'h00)) begin
            nxt_r.env = (r_ff.sym_cnt == 8'hFF);
         end else begin
            nxt_r.env = (r_ff.sym_cnt == r_ff.sym_val);
         end
      end else begin
         nxt_r.env = code_level(coding, r_ff.cur_bit, r_ff.slot, TX_COLLIDE_IN,
                                r_ff.subc, r_ff.data_code[3]);
      end

      // Monitor inputs cross in through two flops
      nxt_r.mon_s1 = MON_IN;
      nxt_r.mon_s2 = r_ff.mon_s1;
      nxt_r.mon_oe = 1'b1;
      unique case (r_ff.sig_mon[3:0])
         MON_HIZ0, MON_HIZ1: begin
            nxt_r.mon_oe  = 1'b0;
            nxt_r.mon_out = 1'b0;
         end
         MON_LOW:    nxt_r.mon_out = 1'b0;
         MON_HIGH:   nxt_r.mon_out = 1'b1;
         MON_TX_ENV: nxt_r.mon_out = r_ff.env;
         MON_TX_ACT: nxt_r.mon_out = r_ff.tx_active;
         MON_SECURE: nxt_r.mon_out = r_ff.mon_s2[3];
         MON_RX_ENV: nxt_r.mon_out = r_ff.mon_s2[2];
         MON_RX_ACT: nxt_r.mon_out = r_ff.mon_s2[1];
         MON_RX_BIT: nxt_r.mon_out = r_ff.mon_s2[0];
         // Undefined selects keep the pin released rather than guessing a source
         default: begin
            nxt_r.mon_oe  = 1'b0;
            nxt_r.mon_out = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         r_ff           <= '0;
         r_ff.sig_mon   <= RST_SIG_MON;
         r_ff.bit_fmt   <= RST_TX_BIT_FMT;
         r_ff.data_code <= RST_TX_DATA_CODE;
         r_ff.state     <= ST_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign RD_DATA            = r_ff.rdata;
   assign TX_READY           = (r_ff.state == ST_IDLE);
   assign TX_ENV_OUT         = r_ff.env;
   assign TX_ACTIVE_OUT      = r_ff.tx_active;
   assign FAST_PAD_SWITCHING = r_ff.sig_mon[7];
   assign SIG_MON_OUT        = r_ff.mon_out;
   assign SIG_MON_OE         = r_ff.mon_oe;

endmodule : tccs_top

// *** design/tccs_pkg.sv ***
// Purpose: Shared constants and types for the transmit coding and signal monitor block
// Assumes: 8-bit registers on a plain strobe port, one 25 MHz clock
// Notes:   Register indices are the printed byte offsets
package tccs_pkg;

   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 8;
   localparam logic [7:0]  OFS_SIG_MON       = 8'h47;
   localparam logic [7:0]  OFS_TX_BIT_FMT    = 8'h48;
   localparam logic [7:0]  OFS_TX_DATA_CODE  = 8'h4A;
   localparam logic [7:0]  OFS_TX_CTRL       = 8'h4C;
   localparam logic [7:0]  OFS_TX_STATUS     = 8'h4D;
   localparam logic [7:0]  RST_SIG_MON       = 8'h00;
   localparam logic [7:0]  RST_TX_BIT_FMT    = 8'h00;
   localparam logic [7:0]  RST_TX_DATA_CODE  = 8'h00;
   localparam logic [7:0]  SIG_MON_MASK      = 8'h8F;
   localparam logic [7:0]  BIT_FMT_MASK      = 8'hAB;

   // Monitor sources
   localparam logic [3:0]  MON_HIZ0          = 4'h0;
   localparam logic [3:0]  MON_HIZ1          = 4'h1;
   localparam logic [3:0]  MON_LOW           = 4'h2;
   localparam logic [3:0]  MON_HIGH          = 4'h3;
   localparam logic [3:0]  MON_TX_ENV        = 4'h4;
   localparam logic [3:0]  MON_TX_ACT        = 4'h5;
   localparam logic [3:0]  MON_SECURE        = 4'h6;
   localparam logic [3:0]  MON_RX_ENV        = 4'h7;
   localparam logic [3:0]  MON_RX_ACT        = 4'h8;
   localparam logic [3:0]  MON_RX_BIT        = 4'h9;

   // Coding types
   localparam logic [3:0]  CODE_NONE         = 4'h0;
   localparam logic [3:0]  CODE_COLLIDE      = 4'h1;
   localparam logic [3:0]  CODE_RZ1          = 4'h4;
   localparam logic [3:0]  CODE_RZ2          = 4'h5;
   localparam logic [3:0]  CODE_RZ3          = 4'h6;
   localparam logic [3:0]  CODE_RZ3B         = 4'h7;
   localparam logic [3:0]  CODE_1OF4         = 4'h8;
   localparam logic [3:0]  CODE_1OF256       = 4'h9;
   localparam logic [3:0]  CODE_1OF256_Z     = 4'hA;
   localparam logic [3:0]  CODE_1OF256_L     = 4'hB;
   localparam logic [3:0]  CODE_PIE          = 4'hC;

   // Clock and rates
   localparam int          CLK_HZ            = 25_000_000;
   localparam int          SUBC_424_HZ       = 424_000;
   localparam int          SUBC_848_HZ       = 848_000;
   localparam int          RATE_26_HZ        = 26_000;
   localparam int          RATE_53_HZ        = 53_000;
   localparam int          RATE_106_HZ       = 106_000;
   localparam int          RATE_212_HZ       = 212_000;
   localparam int          RATE_424_HZ       = 424_000;
   localparam int          RATE_848_HZ       = 848_000;
   // Slots per bit period: each symbol slot is one quarter of the bit time
   localparam int          SLOTS_PER_BIT     = 4;
   localparam int          CNT_W             = 16;
   localparam logic [CNT_W-1:0] SLOT_848  = CNT_W'(CLK_HZ / (RATE_848_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SLOT_424  = CNT_W'(CLK_HZ / (RATE_424_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SLOT_212  = CNT_W'(CLK_HZ / (RATE_212_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SLOT_106  = CNT_W'(CLK_HZ / (RATE_106_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SLOT_53   = CNT_W'(CLK_HZ / (RATE_53_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SLOT_26   = CNT_W'(CLK_HZ / (RATE_26_HZ * SLOTS_PER_BIT));
   localparam logic [CNT_W-1:0] SUBC_HALF_424 = CNT_W'(CLK_HZ / (SUBC_424_HZ * 2));
   localparam logic [CNT_W-1:0] SUBC_HALF_848 = CNT_W'(CLK_HZ / (SUBC_848_HZ * 2));

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tccs_bus_req_t;

   typedef struct packed {
      logic       tx_env;
      logic       tx_active;
      logic       secure_module_serial_signal;
      logic       rx_env;
      logic       rx_active;
      logic       rx_bit;
   } tccs_mon_in_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_START = 5'b00010,
      ST_DATA  = 5'b00100,
      ST_PAR   = 5'b01000,
      ST_STOP  = 5'b10000
   } tccs_state_t;

endpackage : tccs_pkg

// *** sim/tccs_top_asserts.sv ***
// Purpose: Port checks for the transmit coding and monitor block
// Assumes: One clock, async active-low reset
// Notes:   Register copies are rebuilt from bus writes
module tccs_chk
   import tccs_pkg::*;
(
   input wire logic                    CLK,
   input wire logic                    RST_N,
   input wire tccs_pkg::tccs_bus_req_t BUS_REQ,
   input wire logic [7:0]              RD_DATA,
   input wire logic                    TX_LOAD,
   input wire tccs_pkg::tccs_mon_in_t  MON_IN,
   input wire logic                    TX_READY,
   input wire logic                    TX_ENV_OUT,
   input wire logic                    TX_ACTIVE_OUT,
   input wire logic                    FAST_PAD_SWITCHING,
   input wire logic                    SIG_MON_OUT,
   input wire logic                    SIG_MON_OE
);
   import tccs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mon_ff, fmt_ff, code_ff;
   logic [3:0] age_ff;
   logic       settled;
   logic [3:0] sel;
   assign sel     = mon_ff[3:0];
   // Select needs a few cycles to reach the pin
   assign settled = (age_ff >= 4'h3);
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mon_ff  <= 8'h00;
         fmt_ff  <= 8'h00;
         code_ff <= 8'h00;
         age_ff  <= 4'hF;
      end else begin
         if (BUS_REQ.wr && BUS_REQ.addr == OFS_SIG_MON) mon_ff <= BUS_REQ.wdata;
         if (BUS_REQ.wr && BUS_REQ.addr == OFS_TX_BIT_FMT) fmt_ff <= BUS_REQ.wdata;
         if (BUS_REQ.wr && BUS_REQ.addr == OFS_TX_DATA_CODE) code_ff <= BUS_REQ.wdata;
         if (BUS_REQ.wr && BUS_REQ.addr == OFS_SIG_MON) age_ff <= 4'h0;
         else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_PAD_SPEED: assert property (BUS_REQ.wr && BUS_REQ.addr == OFS_SIG_MON
      |=> FAST_PAD_SWITCHING == $past(BUS_REQ.wdata[7])) else $error("pad speed wrong");
   AST_MON_RELEASE: assert property (settled && sel <= 4'h1 |-> !SIG_MON_OE)
      else $error("monitor pin driven");
   AST_MON_LOW: assert property (settled && sel == MON_LOW |-> SIG_MON_OE && !SIG_MON_OUT)
      else $error("monitor pin not low");
   AST_MON_HIGH: assert property (settled && sel == MON_HIGH |-> SIG_MON_OE && SIG_MON_OUT)
      else $error("monitor pin not high");
   AST_MON_TX_ENV: assert property (settled && sel == MON_TX_ENV |-> SIG_MON_OE &&
      (SIG_MON_OUT == TX_ENV_OUT || SIG_MON_OUT == $past(TX_ENV_OUT))) else $error("envelope not shown");
   AST_MON_TX_ACT: assert property (settled && sel == MON_TX_ACT |-> SIG_MON_OE &&
      (SIG_MON_OUT == TX_ACTIVE_OUT || SIG_MON_OUT == $past(TX_ACTIVE_OUT))) else $error("active not shown");
   AST_MON_RX_ACT: assert property ((settled && sel == MON_RX_ACT && $stable(MON_IN.rx_active))[*5]
      |-> SIG_MON_OUT == MON_IN.rx_active) else $error("rx active not shown");
   AST_LOAD_START: assert property (TX_READY && TX_LOAD |=> TX_ACTIVE_OUT && !TX_READY)
      else $error("frame did not start");
   AST_READ_FMT: assert property (BUS_REQ.rd && BUS_REQ.addr == OFS_TX_BIT_FMT
      |=> RD_DATA == ($past(fmt_ff) & 8'hAB)) else $error("bit format readback");
   AST_READ_CODE: assert property (BUS_REQ.rd && BUS_REQ.addr == OFS_TX_DATA_CODE
      |=> RD_DATA == $past(code_ff)) else $error("data coding readback");
   AST_ENV_IDLE: assert property (TX_READY |=> !TX_ENV_OUT)
      else $error("envelope active while idle");
   cover property (settled && sel == MON_TX_ENV && TX_ACTIVE_OUT);
   cover property (TX_READY && TX_LOAD);
   cover property (settled && sel == MON_RX_ACT && SIG_MON_OUT);
endmodule : tccs_chk
bind tccs_top tccs_chk u_tccs_chk (.CLK(CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .RD_DATA(RD_DATA),
   .TX_LOAD(TX_LOAD), .MON_IN(MON_IN), .TX_READY(TX_READY), .TX_ENV_OUT(TX_ENV_OUT),
   .TX_ACTIVE_OUT(TX_ACTIVE_OUT), .FAST_PAD_SWITCHING(FAST_PAD_SWITCHING),
   .SIG_MON_OUT(SIG_MON_OUT), .SIG_MON_OE(SIG_MON_OE));

// *** sim/tccs_card_model.sv ***
// Purpose: Listening card on the far side of the transmit envelope
// Assumes: Bench sets the bit time in clock cycles
// Notes:   No rule binds the card; it only records what it hears
module tccs_card_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        env,
   input  wire logic        active,
   input  wire logic [15:0] bit_cyc,
   output logic      [15:0] bits,
   output logic      [15:0] act_len
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cyc_ff;
   // Mid-bit sampling hides the one-cycle envelope lag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_ff  <= 16'h0;
         bits    <= 16'h0;
         act_len <= 16'h0;
      end else if (active) begin
         cyc_ff  <= cyc_ff + 16'h1;
         act_len <= cyc_ff + 16'h1;
         if (cyc_ff % bit_cyc == bit_cyc / 2) bits <= {bits[14:0], env};
      end else begin
         cyc_ff <= 16'h0;
      end
   end
endmodule : tccs_card_model

// *** sim/tccs_top_bench.sv ***
// Purpose: Self-checking bench for the transmit coding and monitor block
// Assumes: 25 MHz clock, reset held 12 cycles
// Notes:   Envelope polarity is not judged, only bit order and levels
module tccs_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tccs_pkg::*;
   typedef struct packed {logic [7:0] w; logic [5:0] mon; logic oe; logic out;} tccs_row_t;
   localparam tccs_row_t ROWS [13] = '{'{8'h00, 6'h3F, 1'b0, 1'b0}, '{8'h81, 6'h3F, 1'b0, 1'b0},
      '{8'h02, 6'h3F, 1'b1, 1'b0}, '{8'h83, 6'h00, 1'b1, 1'b1}, '{8'h05, 6'h3F, 1'b1, 1'b0},
      '{8'h06, 6'h08, 1'b1, 1'b1}, '{8'h06, 6'h37, 1'b1, 1'b0}, '{8'h87, 6'h04, 1'b1, 1'b1},
      '{8'h07, 6'h3B, 1'b1, 1'b0}, '{8'h08, 6'h02, 1'b1, 1'b1}, '{8'h08, 6'h3D, 1'b1, 1'b0},
      '{8'h09, 6'h01, 1'b1, 1'b1}, '{8'h89, 6'h3E, 1'b1, 1'b0}};
   localparam logic [3:0] CODES [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA,
      4'hB, 4'hC};
   localparam int HZ [8] = '{RATE_26_HZ, RATE_26_HZ, RATE_26_HZ, RATE_53_HZ, RATE_106_HZ, RATE_212_HZ,
      RATE_424_HZ, RATE_848_HZ};
   localparam logic [7:0]  FMT [2] = '{8'hA9, 8'h02};
   localparam logic [15:0] XB [2]  = '{16'h00EB, 16'h0170};
   localparam int          NB [2]  = '{11, 10};
   logic          clk, rst_n, tx_load, tx_parity_en, tx_collide_in;
   tccs_bus_req_t bus_req;
   tccs_mon_in_t  mon_in;
   logic [7:0]    rd_data, tx_byte;
   logic          tx_ready, tx_env, tx_active, fast_pad, mon_out, mon_oe;
   logic [15:0]   bit_cyc, rx_bits, act_len, m;
   int            n_fail, n_compared, e, nb;
   tccs_top u_tccs_top (.CLK(clk), .RST_N(rst_n), .BUS_REQ(bus_req), .RD_DATA(rd_data),
      .TX_LOAD(tx_load), .TX_BYTE(tx_byte), .TX_PARITY_EN(tx_parity_en), .TX_COLLIDE_IN(tx_collide_in),
      .MON_IN(mon_in), .TX_READY(tx_ready), .TX_ENV_OUT(tx_env), .TX_ACTIVE_OUT(tx_active),
      .FAST_PAD_SWITCHING(fast_pad), .SIG_MON_OUT(mon_out), .SIG_MON_OE(mon_oe));
   tccs_card_model u_tccs_card_model (.clk(clk), .rst_n(rst_n), .env(tx_env), .active(tx_active),
      .bit_cyc(bit_cyc), .bits(rx_bits), .act_len(act_len));
   initial clk = 1'b0;
   always #20 clk = ~clk;
   task automatic close_out();
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask : wr_reg
   task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1;
      check("read data", {8'h00, rd_data}, {8'h00, exp});
   endtask : rd_chk
   // Second load mid-frame must be dropped, not queued
   task automatic frame(logic [7:0] b, logic par, int n_bits);
      int k;
      @(posedge clk);
      tx_byte <= b;
      tx_parity_en <= par;
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      @(posedge clk);
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (tx_ready !== 1'b1 && k < 20000);
      repeat (3) @(posedge clk);
      #1;
      check("active after frame", {15'h0, tx_active}, 16'h0);
      e = int'(act_len) - n_bits * int'(bit_cyc);
      check("frame length", {15'h0, e >= -1 && e <= 1}, 16'h1);
   endtask : frame
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      {rst_n, tx_load, tx_parity_en, tx_collide_in, tx_byte} = '0;
      bus_req = '0;
      mon_in = '0;
      bit_cyc = 16'd28;
      n_fail = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check("reset outputs", {12'h0, tx_ready, mon_oe, fast_pad, tx_active}, 16'h8);
      rd_chk(OFS_SIG_MON, 8'h00);
      rd_chk(OFS_TX_BIT_FMT, 8'h00);
      rd_chk(OFS_TX_DATA_CODE, 8'h00);
      wr_reg(8'h4B, 8'hFF);
      rd_chk(8'h4B, 8'h00);
      wr_reg(OFS_TX_BIT_FMT, 8'hFF);
      rd_chk(OFS_TX_BIT_FMT, 8'hAB);
      wr_reg(OFS_TX_DATA_CODE, 8'hFF);
      rd_chk(OFS_TX_DATA_CODE, 8'hFF);
      foreach (ROWS[i]) begin
         @(posedge clk);
         mon_in <= tccs_mon_in_t'(ROWS[i].mon);
         wr_reg(OFS_SIG_MON, ROWS[i].w);
         repeat (6) @(posedge clk);
         #1;
         check("monitor pin", {14'h0, mon_oe, mon_out & mon_oe}, {14'h0, ROWS[i].oe, ROWS[i].out});
         check("pad speed", {15'h0, fast_pad}, {15'h0, ROWS[i].w[7]});
         rd_chk(OFS_SIG_MON, ROWS[i].w & 8'h8F);
      end
      wr_reg(OFS_TX_DATA_CODE, 8'h07);
      wr_reg(OFS_SIG_MON, 8'h05);
      for (int i = 0; i < 2; i++) begin
         wr_reg(OFS_TX_BIT_FMT, FMT[i]);
         frame(8'h3A, 1'b1, NB[i]);
         m = (16'h1 << NB[i]) - 16'h1;
         check("bit stream", {15'h0, ((rx_bits ^ XB[i]) & m) == 0 || ((~rx_bits ^ XB[i]) & m) == 0}, 16'h1);
      end
      wr_reg(OFS_TX_BIT_FMT, 8'h00);
      // Reserved rates 0h and 1h run at the slowest rate
      for (int r = 0; r < 8; r++) begin
         wr_reg(OFS_TX_DATA_CODE, 8'(r));
         bit_cyc = 16'(4 * (CLK_HZ / (HZ[r] * 4)));
         frame(8'hC5, 1'b0, 9);
      end
      wr_reg(OFS_SIG_MON, 8'h04);
      @(posedge clk);
      tx_collide_in <= 1'b1;
      bit_cyc = 16'd28;
      foreach (CODES[c]) begin
         wr_reg(OFS_TX_DATA_CODE, {CODES[c], 4'h7});
         nb = (CODES[c] == 4'h8) ? 5 : (CODES[c] >= 4'h9 && CODES[c] <= 4'hB) ? 65 : 9;
         frame(8'h00, 1'b0, nb);
      end
      close_out();
   end
endmodule : tccs_top_bench
